// ==== hw/ulsm_chirp_timer.v ====
/*
 Chirp duration checker. Measures how long a chirp level stands and
 reports on its end whether the length lay inside the legal window.
 Assumes the chirp level input is synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "ulsm_defs.vh"

module ulsm_chirp_timer
#(
   parameter MIN_CYC = `ULSM_CHIRP_MIN_CYC,
   parameter MAX_CYC = `ULSM_CHIRP_MAX_CYC
)
(
   input  wire clk_sys,
   input  wire sys_rst,
   input  wire chirpLevel,
   output reg  chirpGood,
   output reg  chirpEnd
);

   reg  [`ULSM_CNT_W-1:0] count;
   reg                    prevLevel;
   wire                   inWindow;

   // Length check, inclusive on both ends
   assign inWindow = (count >= MIN_CYC[`ULSM_CNT_W-1:0]) &&
                     (count <= MAX_CYC[`ULSM_CNT_W-1:0]);   // RULE5

   ////////////////////////////////////////////////////////////////////
   // Count while the level stands; saturate past the window
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         count     <= {`ULSM_CNT_W{1'b0}};
         prevLevel <= 1'b0;
         chirpGood <= 1'b0;
         chirpEnd  <= 1'b0;
      end
      else
      begin
         prevLevel <= chirpLevel;
         chirpEnd  <= prevLevel & ~chirpLevel;
         chirpGood <= prevLevel & ~chirpLevel & inWindow;   // RULE5
         if (chirpLevel)
         begin
            if (count <= MAX_CYC[`ULSM_CNT_W-1:0])
               count <= count + {{(`ULSM_CNT_W-1){1'b0}}, 1'b1};
         end
         else
            count <= {`ULSM_CNT_W{1'b0}};
      end
   end

endmodule

// ==== hw/ulsm_link_monitor.v ====
/*
 Link-state monitor of a two-port high-speed signal conditioner:
 attach and high-speed flags, boost latch and regulator enable.
 Assumes digitised line levels of both ports synchronous to clk_sys,
 plus detector pulses for test-packet pattern and suspend entry.
*/
// How it works
// RULE1 - Pull-up seen on either data line from unconnected raises attach flag.
// RULE2 - Disconnect detection clears the attach flag.
// RULE3 - Test fixture from unconnected, then test packet, raises high-speed flag.
// RULE4 - Squelch after bus reset with good handshake raises high-speed flag.
// RULE5 - Handshake good after one chirp J then K, each 18 to 128 us.
// RULE6 - Disconnect or suspend clears the high-speed flag.
// RULE7 - Boost select sampled once after power-up, later changes ignored.
// RULE8 - Floating boost select picks the minimum boost level.
// RULE9 - Low disable input disables; high or undriven enables.
// RULE10 - While disabled both flags are held low.
// RULE11 - Core regulator on only in high-speed mode.
// RULE12 - Both ports are treated alike; either may face the host.
// RULE13 - Flags hold until their own clear condition or disable.
`timescale 1ns/1ps
`include "ulsm_defs.vh"

module ulsm_link_monitor
#(
   parameter MIN_CYC = `ULSM_CHIRP_MIN_CYC,
   parameter MAX_CYC = `ULSM_CHIRP_MAX_CYC
)
(
   input  wire                     clk_sys,
   input  wire                     sys_rst,
   input  wire                     disable_n_input,
   input  wire                     port_a_pos,
   input  wire                     port_a_neg,
   input  wire                     port_b_pos,
   input  wire                     port_b_neg,
   input  wire                     squelch,
   input  wire                     fixtureDetect,
   input  wire                     testPacketSeen,
   input  wire                     suspendDetect,
   input  wire                     disconnectDetect,
   input  wire [`ULSM_BOOST_W-1:0] boost_select,
   input  wire                     boostFloating,
   output reg                      attach_flag,
   output reg                      hs_active_flag,
   output reg                      core_regulator_out,
   output reg  [`ULSM_BOOST_W-1:0] boostLevel
);

   // States, one-hot
   localparam [5:0] ST_UNCONN  = 6'h01;
   localparam [5:0] ST_ATTACH  = 6'h02;
   localparam [5:0] ST_WAITK   = 6'h04;
   localparam [5:0] ST_WAITSQ  = 6'h08;
   localparam [5:0] ST_HS      = 6'h10;
   localparam [5:0] ST_FIXTURE = 6'h20;

   reg  [5:0] state;
   reg  [5:0] next_state;
   reg        boostTaken;
   reg        inReset;
   wire       offState;
   wire [1:0] lineA;
   wire [1:0] lineB;
   wire       pullUpSeen;
   wire       chirpJ;
   wire       chirpK;
   wire       jGood;
   wire       kGood;
   wire       jEnd;
   wire       kEnd;
   wire       jLevel;
   wire       kLevel;

   // Line state of one port from its two data lines
   function [1:0] lineState;
      input pos;
      input neg;
      begin
         lineState = {pos, neg};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Port decode, same for both ports
   assign offState   = sys_rst | ~disable_n_input;   // RULE9
   assign lineA      = lineState(port_a_pos, port_a_neg);   // RULE12
   assign lineB      = lineState(port_b_pos, port_b_neg);   // RULE12
   assign pullUpSeen = (lineA == `ULSM_LS_J) || (lineA == `ULSM_LS_K) ||
                       (lineB == `ULSM_LS_J) || (lineB == `ULSM_LS_K);   // RULE1
   assign chirpJ     = (lineA == `ULSM_LS_J) || (lineB == `ULSM_LS_J);
   assign chirpK     = (lineA == `ULSM_LS_K) || (lineB == `ULSM_LS_K);

   // Chirps are timed from their first cycle on the line: J from idle on,
   // K while the J result is still being judged, so no cycle is lost
   assign jLevel     = chirpJ & ~chirpK &
                       ((state == ST_UNCONN) | (state == ST_ATTACH));   // RULE5
   assign kLevel     = chirpK & ~chirpJ &
                       ((state == ST_ATTACH) | (state == ST_WAITK));    // RULE5

   ////////////////////////////////////////////////////////////////////
   // Chirp length checks
   ulsm_chirp_timer #(.MIN_CYC(MIN_CYC), .MAX_CYC(MAX_CYC)) jTimer
   (
      .clk_sys    (clk_sys),
      .sys_rst    (offState),
      .chirpLevel (jLevel),
      .chirpGood  (jGood),
      .chirpEnd   (jEnd)
   );

   ulsm_chirp_timer #(.MIN_CYC(MIN_CYC), .MAX_CYC(MAX_CYC)) kTimer
   (
      .clk_sys    (clk_sys),
      .sys_rst    (offState),
      .chirpLevel (kLevel),
      .chirpGood  (kGood),
      .chirpEnd   (kEnd)
   );

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always @*
   begin
      next_state = state;
      case (state)
         ST_UNCONN:
         begin
            if (fixtureDetect)
               next_state = ST_FIXTURE;   // RULE3
            else if (pullUpSeen)
               next_state = ST_ATTACH;    // RULE1
         end
         ST_FIXTURE:
         begin
            if (disconnectDetect)
               next_state = ST_UNCONN;
            else if (suspendDetect)
               next_state = ST_FIXTURE;   // RULE6
            else if (testPacketSeen)
               next_state = ST_HS;        // RULE3
         end
         ST_ATTACH:
         begin
            if (disconnectDetect)
               next_state = ST_UNCONN;    // RULE2
            else if (jGood)
               next_state = ST_WAITK;     // RULE5
         end
         ST_WAITK:
         begin
            if (disconnectDetect)
               next_state = ST_UNCONN;
            else if (kGood)
               next_state = ST_WAITSQ;    // RULE5
            else if (kEnd)
               next_state = ST_ATTACH;
         end
         ST_WAITSQ:
         begin
            if (disconnectDetect)
               next_state = ST_UNCONN;
            else if (suspendDetect)
               next_state = ST_ATTACH;
            else if (squelch)
               next_state = ST_HS;        // RULE4
         end
         ST_HS:
         begin
            if (disconnectDetect)
               next_state = ST_UNCONN;    // RULE6
            else if (suspendDetect)
               next_state = ST_ATTACH;    // RULE6
         end
         default:
            next_state = ST_UNCONN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // State and flag registers; disable forces flags low
   always @(posedge clk_sys)
   begin
      if (offState)
      begin
         state              <= ST_UNCONN;
         attach_flag        <= 1'b0;   // RULE10
         hs_active_flag     <= 1'b0;   // RULE10
         core_regulator_out <= 1'b0;
      end
      else
      begin
         state              <= next_state;
         attach_flag        <= (next_state != ST_UNCONN) &&
                               (next_state != ST_FIXTURE);   // RULE13
         hs_active_flag     <= (next_state == ST_HS);        // RULE13
         core_regulator_out <= (next_state == ST_HS);        // RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Boost select caught once, on the first edge after reset release
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         boostTaken <= 1'b0;
         inReset    <= 1'b1;
         boostLevel <= `ULSM_BOOST_MIN;
      end
      else
      begin
         inReset <= 1'b0;
         if (!boostTaken && inReset)
         begin
            boostTaken <= 1'b1;   // RULE7
            boostLevel <= boostFloating ? `ULSM_BOOST_MIN : boost_select;   // RULE8
         end
      end
   end

endmodule

// ==== shared/ulsm_defs.vh ====
/*
 Constants for the USB link-state monitor: chirp timing, boost levels
 and line-state codes. Assumes a 40 MHz system clock.
*/
`ifndef ULSM_DEFS_VH
`define ULSM_DEFS_VH

// System clock rate in kHz
`define ULSM_CLK_KHZ        40000
// Chirp window in microseconds
`define ULSM_CHIRP_MIN_US   18
`define ULSM_CHIRP_MAX_US   128
// Cycle counts: least time rounds up, longest rounds down
`define ULSM_CHIRP_MIN_CYC  ((`ULSM_CHIRP_MIN_US * `ULSM_CLK_KHZ + 999) / 1000)
`define ULSM_CHIRP_MAX_CYC  ((`ULSM_CHIRP_MAX_US * `ULSM_CLK_KHZ) / 1000)
// Width of chirp duration counter
`define ULSM_CNT_W          13
// Boost level codes
`define ULSM_BOOST_W        2
`define ULSM_BOOST_MIN      2'h3
// Line-state codes (pos,neg)
`define ULSM_LS_SE0         2'h0
`define ULSM_LS_K           2'h1
`define ULSM_LS_J           2'h2
`define ULSM_LS_SE1         2'h3

`endif

// ==== test/ulsm_line_model.sv ====
/*
 Far-side USB party: puts line states on one of the two ports.
 Assumes calls just after a rising clk_sys edge.
*/
`timescale 1ns/1ps
module ulsm_line_model
(
   input  wire clk_sys,
   output reg  aPos = 1'b0,
   output reg  aNeg = 1'b0,
   output reg  bPos = 1'b0,
   output reg  bNeg = 1'b0
);
   // Chosen port shows the state; the other sits at SE0 through pull-downs
   task drive(input logic onB, input logic [1:0] ls, input int n);
      begin
         {aPos, aNeg} = onB ? 2'h0 : ls;
         {bPos, bNeg} = onB ? ls : 2'h0;
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
endmodule

// ==== test/ulsm_link_checker.sv ====
/*
 Port checker for the link-state monitor: flag clearing, flag holding,
 regulator tracking and the boost latch.
 Assumes one clock, clk_sys, and a synchronous active-high sys_rst.
*/
`timescale 1ns/1ps
`include "ulsm_defs.vh"
module ulsm_link_checker
(
   input wire                     clk_sys,
   input wire                     sys_rst,
   input wire                     disable_n_input,
   input wire                     squelch,
   input wire                     testPacketSeen,
   input wire                     suspendDetect,
   input wire                     disconnectDetect,
   input wire                     boostFloating,
   input wire                     attach_flag,
   input wire                     hs_active_flag,
   input wire                     core_regulator_out,
   input wire [`ULSM_BOOST_W-1:0] boostLevel
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Flag behaviour
   attach_drop_a: assert property (disconnectDetect && disable_n_input |=> !attach_flag)
      else $error("attach flag stayed up after disconnect");
   hs_drop_a: assert property (disconnectDetect || suspendDetect |=> !hs_active_flag)
      else $error("hs flag stayed up after disconnect or suspend");
   disable_low_a: assert property (!disable_n_input
      |=> !attach_flag && !hs_active_flag)
      else $error("flags up while disabled");
   hs_hold_a: assert property (hs_active_flag && disable_n_input && !disconnectDetect
      && !suspendDetect |=> hs_active_flag)
      else $error("hs flag dropped without cause");
   attach_hold_a: assert property (attach_flag && disable_n_input
      && !disconnectDetect |=> attach_flag)
      else $error("attach flag dropped without cause");
   hs_cause_a: assert property ($rose(hs_active_flag)
      |-> $past(squelch) || $past(testPacketSeen))
      else $error("hs flag rose without squelch or test packet");
   reg_follow_a: assert property (core_regulator_out == hs_active_flag)
      else $error("regulator enable differs from hs mode");
   ////////////////////////////////////////////////////////////////////////////////
   // Boost latch
   boost_hold_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
      |-> $stable(boostLevel))
      else $error("boost level changed after capture");
   boost_float_a: assert property ($past(sys_rst) && boostFloating
      |=> boostLevel == `ULSM_BOOST_MIN)
      else $error("floating boost select not minimum");
   cover property ($rose(hs_active_flag));
   cover property (suspendDetect && hs_active_flag);
   cover property ($fell(attach_flag));
endmodule
bind ulsm_link_monitor ulsm_link_checker CHK
(
   .clk_sys(clk_sys), .sys_rst(sys_rst), .disable_n_input(disable_n_input),
   .squelch(squelch), .testPacketSeen(testPacketSeen), .suspendDetect(suspendDetect),
   .disconnectDetect(disconnectDetect), .boostFloating(boostFloating),
   .attach_flag(attach_flag), .hs_active_flag(hs_active_flag),
   .core_regulator_out(core_regulator_out), .boostLevel(boostLevel)
);

// ==== test/ulsm_link_monitor_tb.sv ====
/*
 Self-checking bench for the link-state monitor: boost latch, attach,
 chirp handshake, fixture entry, suspend, disconnect and disable.
 Assumes short chirp windows of 4 to 10 cycles.
*/
`timescale 1ns/1ps
`include "ulsm_defs.vh"
module ulsm_link_monitor_tb;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        disable_n_input = 1'b1;
   logic [4:0]  ev = 5'h00;
   logic [1:0]  boost_select = 2'h0;
   logic        boostFloating = 1'b1;
   wire         aPos, aNeg, bPos, bNeg, attach_flag, hs_active_flag, core_regulator_out;
   wire  [1:0]  boostLevel;
   logic [3:0]  q[$];
   logic [3:0]  e;
   logic [31:0] seed = 32'h00000063;
   logic [31:0] r;
   int          bad_count = 0;
   int          checks = 0;
   event        look;
   // Clock, 25 ns period
   always #12.5 clk_sys = ~clk_sys;
   ulsm_line_model PM (.clk_sys(clk_sys), .aPos(aPos), .aNeg(aNeg), .bPos(bPos), .bNeg(bNeg));
   ulsm_link_monitor #(.MIN_CYC(4), .MAX_CYC(10)) DUT
   (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .disable_n_input(disable_n_input),
      .port_a_pos(aPos), .port_a_neg(aNeg), .port_b_pos(bPos), .port_b_neg(bNeg),
      .squelch(ev[4]), .fixtureDetect(ev[3]), .testPacketSeen(ev[2]),
      .suspendDetect(ev[1]), .disconnectDetect(ev[0]), .boost_select(boost_select),
      .boostFloating(boostFloating), .attach_flag(attach_flag),
      .hs_active_flag(hs_active_flag), .core_regulator_out(core_regulator_out),
      .boostLevel(boostLevel)
   );
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task note(input logic [3:0] x);
      begin
         q.push_back(x);
         ->look;
      end
   endtask
   task pulse(input logic [4:0] p);
      begin
         ev = p;
         step(1);
         ev = 5'h00;
         step(1);
      end
   endtask
   task reset_to(input logic fl, input logic [1:0] bs);
      begin
         sys_rst = 1'b1;
         boostFloating = fl;
         boost_select = bs;
         step(4);
         sys_rst = 1'b0;
         step(2);
         boost_select = ~bs;
         step(2);
         note({2'b10, fl ? `ULSM_BOOST_MIN : bs});
      end
   endtask
   task cmp(input string what, input logic [2:0] exp, input logic [2:0] got);
      begin
         checks++;
         if (got !== exp)
         begin
            bad_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task cmp_boost(input string what, input logic [1:0] exp, input logic [1:0] got);
      begin
         checks++;
         if (got !== exp)
         begin
            bad_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task close_out;
      begin
         if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   // Result watcher: oldest note against outputs
   always @(look)
   begin
      @(negedge clk_sys);
      e = q.pop_front();
      if (e[3])
         cmp_boost("boostLevel", e[1:0], boostLevel);
      else
         cmp("flags", e[2:0], {attach_flag, hs_active_flag, core_regulator_out});
   end
   // Watchdog
   initial
   begin
      #50000;
      bad_count++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      r = rnd();
      reset_to(1'b1, r[1:0]);
      r = rnd();
      reset_to(1'b0, r[1:0]);
      r = rnd();
      PM.drive(r[0], `ULSM_LS_J, 5 + r[3:1] % 5);
      PM.drive(r[0], `ULSM_LS_K, 5 + r[6:4] % 5);
      PM.drive(r[0], `ULSM_LS_SE0, 3);
      note(4'h4);
      pulse(5'h10);
      note(4'h7);
      pulse(5'h02);
      note(4'h4);
      pulse(5'h01);
      note(4'h0);
      PM.drive(~r[0], `ULSM_LS_J, 2);
      PM.drive(~r[0], `ULSM_LS_K, 6);
      PM.drive(~r[0], `ULSM_LS_SE0, 3);
      pulse(5'h10);
      note(4'h4);
      PM.drive(r[0], `ULSM_LS_J, 6);
      PM.drive(r[0], `ULSM_LS_K, 2);
      PM.drive(r[0], `ULSM_LS_SE0, 3);
      pulse(5'h10);
      note(4'h4);
      pulse(5'h01);
      pulse(5'h08);
      pulse(5'h04);
      note(4'h7);
      disable_n_input = 1'b0;
      step(2);
      note(4'h0);
      disable_n_input = 1'b1;
      step(2);
      PM.drive(r[0], `ULSM_LS_J, 2);
      note(4'h4);
      step(1);
      close_out();
   end
endmodule
